// File: design/mosc_pkg.sv
package mosc_pkg;

    // control register A fields
    typedef struct packed {
        logic voltageCurrentSelect; // 0 voltage mode, 1 current mode
        logic directAccess;
        logic outputMasterEnable;
    } mosc_ctrla_s;

    // control register B fields
    typedef struct packed {
        logic       capturePolarity;
        logic       hwDemagMode;
        logic       swDemagMode;
        logic [2:0] pwmOutputConfig;
    } mosc_ctrlb_s;

    // phase state register fields
    typedef struct packed {
        logic [1:0] sampleSel;
        logic [5:0] outEn;
    } mosc_phase_s;

    // step phase of the running motor
    typedef enum logic [1:0] {
        MOSC_ST_DRIVE = 2'b01,
        MOSC_ST_DEMAG = 2'b10
    } mosc_step_e;

    // timer register select codes
    localparam logic [2:0] MOSC_SEL_TIMER    = 3'h0;
    localparam logic [2:0] MOSC_SEL_PREVZERO = 3'h1;
    localparam logic [2:0] MOSC_SEL_ZERO     = 3'h2;
    localparam logic [2:0] MOSC_SEL_COMPARE  = 3'h3;
    localparam logic [2:0] MOSC_SEL_DEMAG    = 3'h4;
    localparam logic [2:0] MOSC_SEL_PRESCALE = 3'h5;

    // reset values and constants
    localparam logic [7:0] MOSC_BYTE_RST     = 8'h00;
    localparam logic [3:0] MOSC_PRESCALE_RST = 4'h0;
    localparam logic [3:0] MOSC_PRESCALE_MAX = 4'hF;
    localparam logic [7:0] MOSC_SAT_BASE     = 8'h7F;
    localparam logic [8:0] MOSC_SAT_LIMIT    = 9'h0FF;
    localparam logic [2:0] MOSC_OS_NO_PWM    = 3'h2;
    localparam logic [5:0] MOSC_EVEN_ALL     = 6'h00;

endpackage

// File: design/mosc_motor_output_stage.sv
// Notes on behaviour
// - step configuration except the low two pwm config bits goes through shadows, applied at commutation, or at phase write in direct access
// - timer, prescaler and compare writable only while timer clock stopped
// - enable off tristates and stops timer; direct access drives phase register
// - in direct access, phase writes act on outputs at once
// - group bit 0 puts channel in even group, 1 in odd group
// - pwm routed to even, odd or both groups, alternately or together
// - pwm config field decoded differently in voltage and current mode
// - during demagnetization the preloaded top config bit picks pwm mode
// - low two config bits pick pwm between demag end and commutation
// - voltage mode config 010 applies no pwm, active outputs fully on
// - emergency stop low tristates outputs without any clock edge
// - emergency stop clears master output enable
// - emergency stop raises interrupt only when its enable bit set
// - emergency tristate and enable clear work with the clock stopped; the interrupt needs a clock edge
// - demag sum overflow stores 7Fh plus half the excess over FFh
// - prescaler only stepped by hardware while running
`timescale 1ns/1ns
module mosc_motor_output_stage (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    // control register writes
    input  wire logic                 ctrlAWr,
    input  wire mosc_pkg::mosc_ctrla_s ctrlAIn,
    input  wire logic                 ctrlBWr,
    input  wire mosc_pkg::mosc_ctrlb_s ctrlBIn,
    input  wire logic                 phaseWr,
    input  wire mosc_pkg::mosc_phase_s phaseIn,
    input  wire logic                 polarityWr,
    input  wire logic [5:0]           polarityIn,
    input  wire logic                 groupWr,
    input  wire logic [5:0]           groupIn,
    input  wire logic                 irqMaskWr,
    input  wire logic                 irqEnableIn,
    // timer register writes
    input  wire logic                 timerWr,
    input  wire logic [2:0]           timerSel,
    input  wire logic [7:0]           timerData,
    input  wire logic                 demagSumWr,
    input  wire logic [7:0]           demagTime,
    // peripheral events
    input  wire logic                 commEvent,
    input  wire logic                 demagEndEvent,
    input  wire logic                 zeroEvent,
    input  wire logic                 prescaleInc,
    input  wire logic                 prescaleDec,
    input  wire logic                 pwmIn,
    // emergency stop, active low
    input  wire logic                 emergencyStopN,
    // motor outputs
    output logic [5:0]                motorOut,
    output logic [5:0]                motorOutOeN,
    output logic                      emergencyIrq,
    // status
    output logic                      masterEnable,
    output logic                      timerRunning,
    output mosc_pkg::mosc_step_e      stepState,
    output mosc_pkg::mosc_ctrlb_s     ctrlBActive,
    output mosc_pkg::mosc_phase_s     phaseActive,
    output logic [7:0]                stepTimer,
    output logic [7:0]                prevZeroCapture,
    output logic [7:0]                zeroCapture,
    output logic [7:0]                commutationCompare,
    output logic [7:0]                demagCaptureCompare,
    output logic [3:0]                stepPrescaler
);
    import mosc_pkg::*;

    logic        directAccess;
    logic        voltageCurrentSelect;
    logic        irqEnable;
    logic [5:0]  outputPolarity;
    logic [5:0]  outputGroup;
    mosc_ctrlb_s ctrlBShadow;
    mosc_phase_s phaseShadow;
    logic [3:0]  prescaleCount;
    logic        altGroup;
    logic        pwmPrev;
    logic        stopPrev;
    logic        clkEnabled;
    logic        applyStep;
    logic        prescaleTick;
    logic [8:0]  demagSum;
    logic [7:0]  demagValue;
    logic        pwmEven;
    logic        pwmOdd;
    logic [5:0]  switchOn;
    logic [5:0]  next_motorOut;

    ////////////////////////////////////////////////////////////////////////
    // mode decode
    ////////////////////////////////////////////////////////////////////////

    // timer clock runs only in standard running mode
    assign clkEnabled = masterEnable & ~directAccess;
    // shadows move to active copies together
    assign applyStep = directAccess ? phaseWr : (clkEnabled & commEvent);

    // master enable, cleared asynchronously by emergency stop
    always_ff @(posedge clk or negedge emergencyStopN) begin
        if (!emergencyStopN) begin
            masterEnable <= 1'b0;
        end else if (sys_rst) begin
            masterEnable <= 1'b0;
        end else if (ctrlAWr) begin
            masterEnable <= ctrlAIn.outputMasterEnable;
        end
    end

    // remaining control register A bits and interrupt enable
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            directAccess         <= 1'b0;
            voltageCurrentSelect <= 1'b0;
            irqEnable            <= 1'b0;
        end else begin
            if (ctrlAWr) begin
                directAccess         <= ctrlAIn.directAccess;
                voltageCurrentSelect <= ctrlAIn.voltageCurrentSelect;
            end
            if (irqMaskWr) begin
                irqEnable <= irqEnableIn;
            end
        end
    end

    // polarity and group registers act immediately
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            outputPolarity <= 6'h00;
            outputGroup    <= MOSC_EVEN_ALL;
        end else begin
            if (polarityWr) begin
                outputPolarity <= polarityIn;
            end
            if (groupWr) begin
                outputGroup <= groupIn;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // preloaded step configuration
    ////////////////////////////////////////////////////////////////////////

    // shadow copies written by software
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrlBShadow <= '0;
            phaseShadow <= '0;
        end else begin
            if (ctrlBWr) begin
                ctrlBShadow <= ctrlBIn;
            end
            if (phaseWr) begin
                phaseShadow <= phaseIn;
            end
        end
    end

    // active copies; low config bits are not preloaded
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrlBActive <= '0;
            phaseActive <= '0;
        end else begin
            if (applyStep) begin
                ctrlBActive.capturePolarity    <= ctrlBShadow.capturePolarity;
                ctrlBActive.hwDemagMode        <= ctrlBShadow.hwDemagMode;
                ctrlBActive.swDemagMode        <= ctrlBShadow.swDemagMode;
                ctrlBActive.pwmOutputConfig[2] <= ctrlBShadow.pwmOutputConfig[2];
                phaseActive <= directAccess ? phaseIn : phaseShadow;
            end
            if (ctrlBWr) begin
                ctrlBActive.pwmOutputConfig[1:0] <= ctrlBIn.pwmOutputConfig[1:0];
            end
        end
    end

    // demagnetization runs from commutation to demag end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stepState <= MOSC_ST_DRIVE;
        end else begin
            case (stepState)
                MOSC_ST_DRIVE: begin
                    if (clkEnabled && commEvent) begin
                        stepState <= MOSC_ST_DEMAG;
                    end
                end
                MOSC_ST_DEMAG: begin
                    if (demagEndEvent || !clkEnabled) begin
                        stepState <= MOSC_ST_DRIVE;
                    end
                end
                default: begin
                    stepState <= MOSC_ST_DRIVE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // step timer, captures and compares
    ////////////////////////////////////////////////////////////////////////

    // prescaler divides the timer clock by two to the field value, and by 16 for any value from 4 up
    assign prescaleTick = (prescaleCount >= ((4'h1 << stepPrescaler) - 4'h1))
                          | (stepPrescaler == MOSC_PRESCALE_RST);

    // demag sum saturates into the range 7Fh to FEh
    assign demagSum   = {1'b0, commutationCompare} + {1'b0, demagTime};
    assign demagValue = (demagSum > MOSC_SAT_LIMIT)
                        ? MOSC_SAT_BASE + 8'((demagSum - MOSC_SAT_LIMIT) >> 1)
                        : demagSum[7:0];

    // timer counter and prescaler divider
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stepTimer     <= MOSC_BYTE_RST;
            prescaleCount <= 4'h0;
        end else if (clkEnabled) begin
            if (commEvent) begin
                stepTimer     <= MOSC_BYTE_RST;
                prescaleCount <= 4'h0;
            end else if (prescaleTick) begin
                stepTimer     <= stepTimer + 8'h01;
                prescaleCount <= 4'h0;
            end else begin
                prescaleCount <= prescaleCount + 4'h1;
            end
        end else if (timerWr && timerSel == MOSC_SEL_TIMER) begin
            stepTimer <= timerData;
        end
    end

    // captures and compares, loaded by timer writes only while stopped; demag sum writes load at any time
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prevZeroCapture     <= MOSC_BYTE_RST;
            zeroCapture         <= MOSC_BYTE_RST;
            commutationCompare  <= MOSC_BYTE_RST;
            demagCaptureCompare <= MOSC_BYTE_RST;
        end else if (clkEnabled) begin
            if (zeroEvent) begin
                prevZeroCapture <= zeroCapture;
                zeroCapture     <= stepTimer;
            end
            if (demagSumWr) begin
                demagCaptureCompare <= demagValue;
            end
        end else if (timerWr) begin
            case (timerSel)
                MOSC_SEL_PREVZERO: prevZeroCapture     <= timerData;
                MOSC_SEL_ZERO:     zeroCapture         <= timerData;
                MOSC_SEL_COMPARE:  commutationCompare  <= timerData;
                MOSC_SEL_DEMAG:    demagCaptureCompare <= timerData;
                default:           ;
            endcase
        end else if (demagSumWr) begin
            demagCaptureCompare <= demagValue;
        end
    end

    // prescaler: software value before start, hardware steps after
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stepPrescaler <= MOSC_PRESCALE_RST;
        end else if (clkEnabled) begin
            if (prescaleInc && stepPrescaler != MOSC_PRESCALE_MAX) begin
                stepPrescaler <= stepPrescaler + 4'h1;
            end else if (prescaleDec && stepPrescaler != MOSC_PRESCALE_RST) begin
                stepPrescaler <= stepPrescaler - 4'h1;
            end
        end else if (timerWr && timerSel == MOSC_SEL_PRESCALE) begin
            stepPrescaler <= timerData[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pwm routing and output stage
    ////////////////////////////////////////////////////////////////////////

    // group selector for alternate chopping flips on each pwm period
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            altGroup <= 1'b0;
            pwmPrev  <= 1'b0;
        end else begin
            pwmPrev <= pwmIn;
            if (pwmIn && !pwmPrev) begin
                altGroup <= ~altGroup;
            end
        end
    end

    // decide which groups carry the pwm
    always_comb begin
        pwmEven = 1'b0;
        pwmOdd  = 1'b0;
        if (!voltageCurrentSelect
            && ctrlBActive.pwmOutputConfig == MOSC_OS_NO_PWM) begin
            pwmEven = 1'b0;
            pwmOdd  = 1'b0;
        end else if (stepState == MOSC_ST_DEMAG) begin
            pwmEven = ~ctrlBActive.pwmOutputConfig[2];
            pwmOdd  = ctrlBActive.pwmOutputConfig[2];
        end else if (!voltageCurrentSelect) begin
            pwmEven = ctrlBActive.pwmOutputConfig[0];
            pwmOdd  = ctrlBActive.pwmOutputConfig[1];
        end else begin
            case (ctrlBActive.pwmOutputConfig[1:0])
                2'h0: pwmEven = 1'b1;
                2'h1: pwmOdd  = 1'b1;
                2'h2: begin
                    pwmEven = ~altGroup;
                    pwmOdd  = altGroup;
                end
                default: begin
                    pwmEven = 1'b1;
                    pwmOdd  = 1'b1;
                end
            endcase
        end
    end

    // switch state per channel, then polarity to pin level
    always_comb begin
        next_motorOut = 6'h00;
        switchOn      = 6'h00;
        for (int i = 0; i < 6; i++) begin
            if (directAccess) begin
                switchOn[i] = phaseActive.outEn[i];
            end else if (outputGroup[i] ? pwmOdd : pwmEven) begin
                switchOn[i] = phaseActive.outEn[i] & pwmIn;
            end else begin
                switchOn[i] = phaseActive.outEn[i];
            end
            next_motorOut[i] = outputPolarity[i] ? switchOn[i]
                                                 : ~switchOn[i];
        end
    end

    // pin levels
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            motorOut <= 6'h00;
        end else begin
            motorOut <= next_motorOut;
        end
    end

    // output enables, forced off asynchronously by emergency stop
    always_ff @(posedge clk or negedge emergencyStopN) begin
        if (!emergencyStopN) begin
            motorOutOeN <= 6'h3F;
        end else if (sys_rst) begin
            motorOutOeN <= 6'h3F;
        end else begin
            motorOutOeN <= {6{~masterEnable}};
        end
    end

    // emergency interrupt pulse and timer status
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stopPrev     <= 1'b1;
            emergencyIrq <= 1'b0;
            timerRunning <= 1'b0;
        end else begin
            stopPrev     <= emergencyStopN;
            emergencyIrq <= stopPrev & ~emergencyStopN & irqEnable;
            timerRunning <= clkEnabled;
        end
    end

endmodule // mosc_motor_output_stage

// File: bench/mosc_switch_model.sv
`timescale 1ns/1ns
module mosc_switch_model (
    // pins from the stage
    input  wire logic [5:0] motorOut,
    input  wire logic [5:0] motorOutOeN,
    input  wire logic [5:0] polarity,
    // fault request from the bench
    input  wire logic       alarmReq,
    // switch states and alarm line
    output logic      [5:0] switchOn,
    output logic            alarmN
);
    // a released gate falls to its pull-down, so the switch is off
    assign switchOn = ~motorOutOeN & ~(motorOut ^ polarity);
    // driver alarm line, active low
    assign alarmN = ~alarmReq;
endmodule // mosc_switch_model

// File: bench/mosc_stage_asserts.sv
`timescale 1ns/1ns
module mosc_stage_asserts
    import mosc_pkg::*;
(
    // clock and reset
    input wire logic                  clk,
    input wire logic                  sys_rst,
    // writes and events
    input wire logic                  ctrlAWr,
    input wire logic                  ctrlBWr,
    input wire mosc_pkg::mosc_ctrlb_s ctrlBIn,
    input wire logic                  irqMaskWr,
    input wire logic                  irqEnableIn,
    input wire logic                  timerWr,
    input wire logic [2:0]            timerSel,
    input wire logic [7:0]            timerData,
    input wire logic                  demagSumWr,
    input wire logic [7:0]            demagTime,
    input wire logic                  commEvent,
    input wire logic                  emergencyStopN,
    // outputs
    input wire logic [5:0]            motorOutOeN,
    input wire logic                  emergencyIrq,
    input wire logic                  masterEnable,
    input wire logic                  timerRunning,
    input wire mosc_pkg::mosc_step_e  stepState,
    input wire mosc_pkg::mosc_ctrlb_s ctrlBActive,
    input wire logic [7:0]            commutationCompare,
    input wire logic [7:0]            demagCaptureCompare
);
    import mosc_pkg::*;
    mosc_ctrlb_s shadowB;
    logic        irqEn;

    // track the preloaded step config and the irq enable
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            shadowB <= '0;
            irqEn   <= 1'b0;
        end else begin
            if (ctrlBWr) shadowB <= ctrlBIn;
            if (irqMaskWr) irqEn <= irqEnableIn;
        end
    end

    // saturated end of demagnetization sum
    function automatic logic [7:0] satSum(logic [7:0] a, logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        if (s > MOSC_SAT_LIMIT) return MOSC_SAT_BASE + 8'((s - 9'h0FF) >> 1);
        return s[7:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    // commutation while running, then the preloads go active
    sequence s_comm;
        commEvent && timerRunning && !ctrlBWr;
    endsequence
    sequence s_loaded;
        stepState == MOSC_ST_DEMAG && ctrlBActive[5:2] == shadowB[5:2];
    endsequence

    property p_comm; s_comm |=> s_loaded; endproperty
    a_comm: assert property (p_comm) else $error("preload not applied");
    property p_stopOe; !emergencyStopN |-> motorOutOeN == 6'h3F; endproperty
    a_stopOe: assert property (p_stopOe) else $error("stop oe");
    property p_stopMe; !emergencyStopN |-> !masterEnable; endproperty
    a_stopMe: assert property (p_stopMe) else $error("stop enable");
    property p_irq; emergencyIrq |-> irqEn && !$past(emergencyStopN); endproperty
    a_irq: assert property (p_irq) else $error("irq cause");
    property p_irqOne; emergencyIrq |=> !emergencyIrq; endproperty
    a_irqOne: assert property (p_irqOne) else $error("irq width");
    property p_oeOff; !masterEnable |=> motorOutOeN == 6'h3F; endproperty
    a_oeOff: assert property (p_oeOff) else $error("oe off");
    property p_run; !masterEnable && !ctrlAWr |=> !timerRunning; endproperty
    a_run: assert property (p_run) else $error("timer run");
    property p_tmHold;
        timerWr && timerSel == MOSC_SEL_COMPARE ##1 timerRunning
            |-> $stable(commutationCompare);
    endproperty
    a_tmHold: assert property (p_tmHold) else $error("compare hold");
    property p_tmLoad;
        timerWr && timerSel == MOSC_SEL_COMPARE ##1 !timerRunning
            |-> commutationCompare == $past(timerData);
    endproperty
    a_tmLoad: assert property (p_tmLoad) else $error("compare load");
    property p_sat;
        demagSumWr |=> demagCaptureCompare
            == satSum($past(commutationCompare), $past(demagTime));
    endproperty
    a_sat: assert property (p_sat) else $error("demag sum");
endmodule // mosc_stage_asserts

bind mosc_motor_output_stage mosc_stage_asserts u_asserts (
    .clk, .sys_rst, .ctrlAWr, .ctrlBWr, .ctrlBIn, .irqMaskWr, .irqEnableIn,
    .timerWr, .timerSel, .timerData, .demagSumWr, .demagTime, .commEvent,
    .emergencyStopN, .motorOutOeN, .emergencyIrq, .masterEnable,
    .timerRunning, .stepState, .ctrlBActive, .commutationCompare,
    .demagCaptureCompare
);

// File: bench/tb.sv
`timescale 1ns/1ns
module tb;
    import mosc_pkg::*;
    localparam int OP_A = 0, OP_B = 1, OP_PH = 2, OP_POL = 3, OP_GRP = 4;
    localparam int OP_IRQ = 5, OP_TM = 6, OP_DS = 7, OP_CE = 8, OP_DE = 9;
    localparam int OP_INC = 10, OP_DEC = 11;
    logic        clk;
    logic        clkRun = 1'b1;
    logic        sys_rst, pwmIn, alarmReq, irqEnableIn;
    logic [11:0] stb;
    logic [7:0]  dat;
    logic [2:0]  timerSel;
    logic [5:0]  pol, polarityIn, groupIn, motorOut, motorOutOeN, switchOn;
    int          miscompares, comparisons;
    logic        ctrlAWr, ctrlBWr, phaseWr, polarityWr, groupWr, irqMaskWr;
    logic        timerWr, demagSumWr, commEvent, demagEndEvent, prescaleInc;
    logic        prescaleDec, emergencyStopN, emergencyIrq, masterEnable;
    logic        timerRunning;
    mosc_ctrla_s ctrlAIn;
    mosc_ctrlb_s ctrlBIn, ctrlBActive;
    mosc_phase_s phaseIn, phaseActive;
    mosc_step_e  stepState;
    logic [7:0]  timerData, demagTime, stepTimer, prevZeroCapture;
    logic [7:0]  zeroCapture, commutationCompare, demagCaptureCompare;
    logic [3:0]  stepPrescaler;
    logic [7:0]  vals [6] = '{8'h11, 8'h22, 8'h33, 8'hC0, 8'h44, 8'h0A};
    logic [19:0] pwmTbl [7] = '{20'h0202A, 20'h01002, 20'h11028,
                                20'h10002, 20'h13000, 20'h1312A, 20'h12028};

    // one-hot strobes and a shared data byte feed every write port
    assign {prescaleDec, prescaleInc, demagEndEvent, commEvent, demagSumWr,
            timerWr, irqMaskWr, groupWr, polarityWr, phaseWr, ctrlBWr,
            ctrlAWr} = stb;
    assign ctrlAIn = dat[2:0];
    assign ctrlBIn = dat[5:0];
    assign phaseIn = dat;
    assign {polarityIn, groupIn, irqEnableIn} = {dat[5:0], dat[5:0], dat[0]};
    assign {timerData, demagTime} = {dat, dat};

    mosc_switch_model u_switch (.motorOut, .motorOutOeN, .polarity(pol),
        .alarmReq, .switchOn, .alarmN(emergencyStopN));
    mosc_motor_output_stage dut (
        .clk, .sys_rst, .ctrlAWr, .ctrlAIn, .ctrlBWr, .ctrlBIn, .phaseWr,
        .phaseIn, .polarityWr, .polarityIn, .groupWr, .groupIn, .irqMaskWr,
        .irqEnableIn, .timerWr, .timerSel, .timerData, .demagSumWr,
        .demagTime, .commEvent, .demagEndEvent, .zeroEvent(1'b0),
        .prescaleInc, .prescaleDec, .pwmIn, .emergencyStopN, .motorOut,
        .motorOutOeN, .emergencyIrq, .masterEnable, .timerRunning,
        .stepState, .ctrlBActive, .phaseActive, .stepTimer,
        .prevZeroCapture, .zeroCapture, .commutationCompare,
        .demagCaptureCompare, .stepPrescaler);

    ////////////////////////////////////////////////////////////////////////
    // gated clock so the stop path can be shown without edges
    initial begin
        clk = 1'b0;
        forever #50 if (clkRun) clk = ~clk;
    end

    task automatic cyc();
        @(negedge clk);
    endtask
    task automatic idle(input int n);
        stb = '0;
        repeat (n) cyc();
    endtask
    // one write or event, held for one rising edge
    task automatic op(input int b, input logic [2:0] s, input logic [7:0] d);
        dat = d;
        timerSel = s;
        stb = 12'(1) << b;
        cyc();
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic report_and_stop();
        if (miscompares == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // bounded look for the emergency interrupt pulse
    task automatic waitIrq(input logic exp);
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < 4; i++) begin
            cyc();
            seen = seen | (emergencyIrq === 1'b1);
        end
        chk("irq", 8'(exp), 8'(seen));
        if (seen !== exp) report_and_stop();
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_rst = 1'b1;
        {stb, dat, timerSel, pol} = '0;
        {pwmIn, alarmReq, miscompares, comparisons} = '0;
        idle(20);
        sys_rst = 1'b0;
        idle(1);
        chk("oe", 8'h3F, 8'(motorOutOeN));
        chk("state", 8'h01, 8'(stepState));
        chk("timer", 8'h00, stepTimer);
        chk("compare", 8'h00, commutationCompare);
        // initial load of every timer register while stopped
        for (int i = 0; i < 6; i++) op(OP_TM, 3'(i), vals[i]);
        idle(1);
        chk("timer", 8'h11, stepTimer);
        chk("prevzero", 8'h22, prevZeroCapture);
        chk("zero", 8'h33, zeroCapture);
        chk("compare", 8'hC0, commutationCompare);
        chk("demag", 8'h44, demagCaptureCompare);
        chk("prescale", 8'h0A, 8'(stepPrescaler));
        // overflow, exact top and just past top of the demag sum
        op(OP_DS, 3'h0, 8'h80);
        idle(1);
        chk("sat", 8'h9F, demagCaptureCompare);
        op(OP_DS, 3'h0, 8'h3F);
        idle(1);
        chk("sat", 8'hFF, demagCaptureCompare);
        op(OP_DS, 3'h0, 8'h40);
        idle(1);
        chk("sat", 8'h7F, demagCaptureCompare);
        // direct access drives the phase register at once
        pol = 6'h0F;
        op(OP_POL, 3'h0, 8'h0F);
        op(OP_A, 3'h0, 8'h03);
        op(OP_PH, 3'h0, 8'h55);
        idle(2);
        chk("phase", 8'h55, phaseActive);
        chk("running", 8'h00, 8'(timerRunning));
        chk("oe", 8'h00, 8'(motorOutOeN));
        chk("pins", 8'h25, 8'(motorOut));
        chk("switch", 8'h15, 8'(switchOn));
        // normal running: next step waits in the shadows
        op(OP_A, 3'h0, 8'h01);
        op(OP_B, 3'h0, 8'h38);
        op(OP_PH, 3'h0, 8'h6A);
        op(OP_TM, MOSC_SEL_COMPARE, 8'h55);
        idle(1);
        chk("phase", 8'h55, phaseActive);
        chk("cfg", 8'h00, 8'(ctrlBActive));
        chk("compare", 8'hC0, commutationCompare);
        pol = 6'h3F;
        op(OP_POL, 3'h0, 8'h3F);
        op(OP_GRP, 3'h0, 8'h07);
        op(OP_CE, 3'h0, 8'h00);
        idle(1);
        chk("state", 8'h02, 8'(stepState));
        chk("cfg", 8'h38, 8'(ctrlBActive));
        chk("phase", 8'h6A, phaseActive);
        chk("timer", 8'h00, stepTimer);
        op(OP_INC, 3'h0, 8'h00);
        chk("switch", 8'h02, 8'(switchOn));
        idle(1);
        chk("prescale", 8'h0B, 8'(stepPrescaler));
        op(OP_DEC, 3'h0, 8'h00);
        op(OP_DE, 3'h0, 8'h00);
        idle(1);
        chk("prescale", 8'h0A, 8'(stepPrescaler));
        chk("state", 8'h01, 8'(stepState));
        // pwm decode after the demag end, voltage and current modes
        for (int i = 0; i < 7; i++) begin
            op(OP_A, 3'h0, {5'h00, pwmTbl[i][16], 2'b01});
            op(OP_B, 3'h0, {5'h00, pwmTbl[i][14:12]});
            pwmIn = pwmTbl[i][8];
            idle(2);
            chk("pwm", pwmTbl[i][7:0], 8'(switchOn));
        end
        // emergency stop with the clock halted, then with the clock running and irq disabled
        op(OP_IRQ, 3'h0, 8'h01);
        idle(1);
        clkRun = 1'b0;
        #20 alarmReq = 1'b1;
        #200 chk("stop oe", 8'h3F, 8'(motorOutOeN));
        chk("stop enable", 8'h00, 8'(masterEnable));
        clkRun = 1'b1;
        waitIrq(1'b1);
        alarmReq = 1'b0;
        op(OP_IRQ, 3'h0, 8'h00);
        op(OP_A, 3'h0, 8'h01);
        idle(1);
        chk("enable", 8'h01, 8'(masterEnable));
        alarmReq = 1'b1;
        waitIrq(1'b0);
        chk("stop enable", 8'h00, 8'(masterEnable));
        report_and_stop();
    end
endmodule // tb
